// ==== utmc_pkg.sv ====
// Purpose: Constants shared by the USB test-mode control block.
// Assumes: Avalon-MM slave with 32-bit data, byte addresses.
// Notes: One register word holds the test-mode byte in its low bits.
package utmc_pkg;
   localparam logic [7:0] UTMC_TEST_CTRL_ADDR = 8'h84; // Test-mode control byte address
   localparam logic [7:0] UTMC_STATUS_ADDR = 8'h88; // Status word address
   localparam logic [7:0] UTMC_TEST_RESET = 8'h00; // Hardware reset value
   localparam logic [7:0] UTMC_WRITE_MASK = 8'h9f; // Writable bits, reserved 6:5 read zero
   localparam logic [7:0] UTMC_PATTERN_MASK = 8'h0f; // Line-state bits cleared by bus reset
   localparam int UTMC_BIT_FORCE_HS = 7; // force_high_speed
   localparam int UTMC_BIT_FORCE_FS = 4; // force_full_speed
   localparam int UTMC_BIT_RANDOM = 3; // random_toggle_pattern
   localparam int UTMC_BIT_K = 2; // drive_k_level
   localparam int UTMC_BIT_J = 1; // drive_j_level
   localparam int UTMC_BIT_QUIET = 0; // hs_quiet_nak_test
   localparam logic [15:0] UTMC_LFSR_SEED = 16'hace1; // Nonzero pattern seed
   localparam logic [15:0] UTMC_LFSR_TAPS = 16'hb400; // Maximal-length taps
   localparam logic [3:0] UTMC_PID_IN = 4'h9; // IN token PID
   localparam logic [3:0] UTMC_PID_NAK = 4'ha; // NAK handshake PID
   localparam logic [31:0] UTMC_ZERO_WORD = 32'h0000_0000; // Unmapped read value

   // Line-drive modes of the transceiver
   typedef enum logic [2:0]
   {
      UTMC_LINE_NORMAL = 3'b000,
      UTMC_LINE_RANDOM = 3'b001,
      UTMC_LINE_K = 3'b010,
      UTMC_LINE_J = 3'b011,
      UTMC_LINE_QUIET = 3'b100
   } utmc_line_t;

   // Speed selection for the transceiver
   typedef enum logic [1:0]
   {
      UTMC_SPEED_AUTO = 2'b00,
      UTMC_SPEED_HS = 2'b01,
      UTMC_SPEED_FS = 2'b10
   } utmc_speed_t;
endpackage : utmc_pkg

// ==== utmc_lfsr.sv ====
// Purpose: Pseudo-random toggle source for the compliance pattern.
// Assumes: Runs only while enabled; restarts from the seed when idle.
// Notes: Galois LFSR, one step per clock.
`timescale 1ns/1ps
module utmc_lfsr
   import utmc_pkg::*;
(
   input wire logic clock_i, // System clock
   input wire logic reset_i, // Synchronous reset, active high
   input wire logic run_i, // Advance the sequence
   output logic bit_o // Current pattern bit
);
   logic [15:0] lfsr_reg;
   logic [15:0] lfsr_next;

   // Step when running, otherwise reload so each pattern starts the same
   assign lfsr_next = !run_i ? UTMC_LFSR_SEED :
      (lfsr_reg[0] ? ((lfsr_reg >> 1) ^ UTMC_LFSR_TAPS) : (lfsr_reg >> 1));

   // Sequence register
   always_ff @(posedge clock_i)
   begin
      if (reset_i)
         lfsr_reg <= UTMC_LFSR_SEED;
      else
         lfsr_reg <= lfsr_next;
   end

   assign bit_o = lfsr_reg[0];
endmodule : utmc_lfsr

// ==== utmc_ctrl.sv ====
// Purpose: Test-mode control for a high-speed USB peripheral transceiver.
// Assumes: Avalon-MM slave; token decode supplied by the packet engine.
// Notes: Entry flag latches until hardware reset; a zero write still clears the mode bits and outputs.
//
// Register access over Avalon-MM and the address map were chosen for this implementation.
`timescale 1ns/1ps
// Contract
// - Force-high-speed bit set: high-speed only, chirp detection disabled.
// - Force-full-speed bit set: full-speed only, chirp detection disabled.
// - Pattern bit set: toggle DP and DM in a fixed pseudo-random sequence.
// - K-level bit set: drive and hold the K bus state.
// - J-level bit set: drive and hold the J bus state.
// - Quiet-NAK bit set: hold lines in high-speed quiescent idle.
// - Quiet-NAK active: answer valid high-speed IN tokens with NAK, ignore others.
// - Hardware reset clears all; bus reset keeps speed bits, clears pattern bits.
// - Test mode persists until power cycle; clearing bits does not exit. Here a zero write returns the outputs to normal; only the entry flag stays.
// - Test-mode control is one writable byte at address 84h.
module utmc_ctrl
   import utmc_pkg::*;
(
   input wire logic clock_i, // System clock, 100 MHz
   input wire logic reset_i, // Hardware reset, synchronous, active high
   input wire logic bus_reset_i, // USB bus reset detected
   input wire logic [7:0] avs_address_i, // Avalon byte address
   input wire logic avs_read_i, // Avalon read
   input wire logic avs_write_i, // Avalon write
   input wire logic [31:0] avs_writedata_i, // Avalon write data
   input wire logic [3:0] avs_byteenable_i, // Avalon byte enables
   output logic [31:0] avs_readdata_o, // Avalon read data
   output logic avs_waitrequest_o, // Avalon wait request
   input wire logic token_valid_i, // Received token pulse
   input wire logic [3:0] token_pid_i, // Received token PID
   input wire logic token_hs_i, // Token received at high speed
   input wire logic token_crc_ok_i, // Token CRC and address valid
   output logic handshake_send_o, // Send handshake pulse
   output logic [3:0] handshake_pid_o, // Handshake PID to send
   output logic rx_ignore_o, // Packet engine discards traffic
   output logic [1:0] speed_sel_o, // utmc_speed_t speed choice
   output logic chirp_enable_o, // Chirp speed detection allowed
   output logic line_drive_o, // Test logic owns DP and DM
   output logic dp_o, // DP level while driving
   output logic dm_o, // DM level while driving
   output logic hs_mode_o // Transceiver in high-speed signalling
);
   logic [7:0] test_reg;
   logic [7:0] test_next;
   logic latched_reg;
   logic latched_next;
   logic ack_reg;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic handshake_send_reg;
   logic handshake_send_next;
   logic [1:0] speed_reg;
   logic chirp_reg;
   logic drive_reg;
   logic dp_reg;
   logic dm_reg;
   logic hs_reg;
   logic ignore_reg;
   logic [7:0] live_bits;
   logic sel_test;
   logic sel_status;
   logic wr_test;
   logic access;
   logic pattern_bit;
   logic in_token_ok;
   utmc_line_t line_mode;
   utmc_speed_t speed_mode;

   // Picks the line mode from the pattern bits, lowest-priority last
   function automatic utmc_line_t utmc_line_of(input logic [7:0] bits);
      utmc_line_t mode;
      mode = UTMC_LINE_NORMAL;
      if (bits[UTMC_BIT_RANDOM])
         mode = UTMC_LINE_RANDOM;
      else if (bits[UTMC_BIT_K])
         mode = UTMC_LINE_K;
      else if (bits[UTMC_BIT_J])
         mode = UTMC_LINE_J;
      else if (bits[UTMC_BIT_QUIET])
         mode = UTMC_LINE_QUIET;
      return mode;
   endfunction : utmc_line_of

   // Bus decode; one wait cycle, and a write lands on the acknowledging edge
   assign access = (avs_read_i | avs_write_i) & !ack_reg;
   assign sel_test = (avs_address_i == UTMC_TEST_CTRL_ADDR);
   assign sel_status = (avs_address_i == UTMC_STATUS_ADDR);
   assign wr_test = ack_reg & avs_write_i & sel_test & avs_byteenable_i[0];

   // Register update: hardware reset clears, bus reset keeps speed bits
   assign test_next = wr_test ? (avs_writedata_i[7:0] & UTMC_WRITE_MASK) :
      (bus_reset_i ? (test_reg & ~UTMC_PATTERN_MASK) : test_reg);

   // Entry flag is sticky until hardware reset; the mode bits stay writable,
   // so a zero write returns the outputs to normal and only the entry flag stays set
   assign latched_next = latched_reg | wr_test & (|(avs_writedata_i[7:0] & UTMC_WRITE_MASK));
   assign live_bits = test_reg;

   // Mode selection; conflicts resolve by fixed priority
   assign line_mode = utmc_line_of(live_bits);
   assign speed_mode = live_bits[UTMC_BIT_FORCE_HS] ? UTMC_SPEED_HS :
      (live_bits[UTMC_BIT_FORCE_FS] ? UTMC_SPEED_FS : UTMC_SPEED_AUTO);

   // Token screening while the quiet-NAK test runs
   assign in_token_ok = token_valid_i & token_hs_i & token_crc_ok_i &
      (token_pid_i == UTMC_PID_IN);
   assign handshake_send_next = (line_mode == UTMC_LINE_QUIET) & in_token_ok;

   // Read data
   assign rdata_next = sel_test ? {24'h00_0000, test_reg} :
      (sel_status ? {23'h00_0000, latched_reg, 5'h00, line_mode} : UTMC_ZERO_WORD);

   utmc_lfsr u_lfsr
   (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .run_i(line_mode == UTMC_LINE_RANDOM),
      .bit_o(pattern_bit)
   );

   // Control state
   always_ff @(posedge clock_i)
   begin
      if (reset_i)
      begin
         test_reg <= UTMC_TEST_RESET;
         latched_reg <= 1'b0;
         ack_reg <= 1'b0;
         rdata_reg <= UTMC_ZERO_WORD;
      end
      else
      begin
         test_reg <= test_next;
         latched_reg <= latched_next;
         ack_reg <= access;
         rdata_reg <= access ? rdata_next : rdata_reg;
      end
   end

   // Speed and chirp outputs
   always_ff @(posedge clock_i)
   begin
      if (reset_i)
      begin
         speed_reg <= UTMC_SPEED_AUTO;
         chirp_reg <= 1'b1;
         hs_reg <= 1'b0;
      end
      else
      begin
         speed_reg <= speed_mode;
         chirp_reg <= (speed_mode == UTMC_SPEED_AUTO);
         hs_reg <= (speed_mode == UTMC_SPEED_HS) | (line_mode == UTMC_LINE_QUIET)
            | (line_mode == UTMC_LINE_RANDOM);
      end
   end

   // Line drive outputs
   always_ff @(posedge clock_i)
   begin
      if (reset_i)
      begin
         drive_reg <= 1'b0;
         dp_reg <= 1'b0;
         dm_reg <= 1'b0;
         ignore_reg <= 1'b0;
         handshake_send_reg <= 1'b0;
      end
      else
      begin
         handshake_send_reg <= handshake_send_next;
         ignore_reg <= (line_mode == UTMC_LINE_QUIET);
         case (line_mode)
            UTMC_LINE_RANDOM:
            begin
               drive_reg <= 1'b1;
               dp_reg <= pattern_bit;
               dm_reg <= !pattern_bit;
            end
            UTMC_LINE_K:
            begin
               drive_reg <= 1'b1;
               dp_reg <= 1'b0;
               dm_reg <= 1'b1;
            end
            UTMC_LINE_J:
            begin
               drive_reg <= 1'b1;
               dp_reg <= 1'b1;
               dm_reg <= 1'b0;
            end
            UTMC_LINE_QUIET:
            begin
               drive_reg <= 1'b1;
               dp_reg <= 1'b0;
               dm_reg <= 1'b0;
            end
            default:
            begin
               drive_reg <= 1'b0;
               dp_reg <= 1'b0;
               dm_reg <= 1'b0;
            end
         endcase
      end
   end

   assign avs_readdata_o = rdata_reg;
   assign avs_waitrequest_o = !ack_reg;
   assign handshake_send_o = handshake_send_reg;
   assign handshake_pid_o = UTMC_PID_NAK;
   assign rx_ignore_o = ignore_reg;
   assign speed_sel_o = speed_reg;
   assign chirp_enable_o = chirp_reg;
   assign line_drive_o = drive_reg;
   assign dp_o = dp_reg;
   assign dm_o = dm_reg;
   assign hs_mode_o = hs_reg;
endmodule : utmc_ctrl

// ==== utmc_monitor.sv ====
// Purpose: Port checks for the test-mode control block.
// Assumes: One clock, synchronous active-high reset.
// Notes: Bound into the control block.
`timescale 1ns/1ps
module utmc_monitor
   import utmc_pkg::*;
(
   input wire logic clock_i, // Clock
   input wire logic reset_i, // Reset
   input wire logic bus_reset_i, // Bus reset
   input wire logic avs_read_i, // Read
   input wire logic avs_write_i, // Write
   input wire logic avs_waitrequest_o, // Wait
   input wire logic token_valid_i, // Token
   input wire logic [3:0] token_pid_i, // PID
   input wire logic token_hs_i, // HS token
   input wire logic token_crc_ok_i, // Good token
   input wire logic handshake_send_o, // Handshake
   input wire logic [3:0] handshake_pid_o, // Handshake PID
   input wire logic rx_ignore_o, // Quiet mode
   input wire logic [1:0] speed_sel_o, // Speed
   input wire logic chirp_enable_o, // Chirp
   input wire logic line_drive_o, // Line owned
   input wire logic dp_o, // DP
   input wire logic dm_o // DM
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (reset_i);
   // Bus answer timing, mode outputs and the quiet-mode reply
   a_wait_one: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("access not answered");
   a_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("answer too long");
   a_reset_vals: assert property ($fell(reset_i) |-> avs_waitrequest_o && chirp_enable_o && !line_drive_o)
      else $error("bad reset state");
   a_chirp_auto: assert property (chirp_enable_o == (speed_sel_o == UTMC_SPEED_AUTO))
      else $error("chirp and speed disagree");
   a_nak_reply: assert property (token_valid_i && token_hs_i && token_crc_ok_i && token_pid_i == UTMC_PID_IN
      && rx_ignore_o |=> handshake_send_o && handshake_pid_o == UTMC_PID_NAK)
      else $error("missing NAK");
   a_nak_only: assert property (handshake_send_o |-> $past(token_valid_i) && $past(token_hs_i)
      && $past(token_crc_ok_i) && $past(token_pid_i) == UTMC_PID_IN)
      else $error("handshake without IN token");
   a_line_pair: assert property (line_drive_o |-> (dp_o != dm_o) || (rx_ignore_o && !dp_o && !dm_o))
      else $error("bad line pair");
   a_bus_clear: assert property (bus_reset_i && !avs_write_i |=> ##1 !line_drive_o && $stable(speed_sel_o))
      else $error("bus reset effect wrong");
endmodule : utmc_monitor
bind utmc_ctrl utmc_monitor i_mon
(
   .clock_i(clock_i),
   .reset_i(reset_i),
   .bus_reset_i(bus_reset_i),
   .avs_read_i(avs_read_i),
   .avs_write_i(avs_write_i),
   .avs_waitrequest_o(avs_waitrequest_o),
   .token_valid_i(token_valid_i),
   .token_pid_i(token_pid_i),
   .token_hs_i(token_hs_i),
   .token_crc_ok_i(token_crc_ok_i),
   .handshake_send_o(handshake_send_o),
   .handshake_pid_o(handshake_pid_o),
   .rx_ignore_o(rx_ignore_o),
   .speed_sel_o(speed_sel_o),
   .chirp_enable_o(chirp_enable_o),
   .line_drive_o(line_drive_o),
   .dp_o(dp_o),
   .dm_o(dm_o)
);

// ==== utmc_host_model.sv ====
// Purpose: Host side token source.
// Assumes: One token at a time.
// Notes: Idle fields show the inverse of the last token.
`timescale 1ns/1ps
module utmc_host_model
   import utmc_pkg::*;
(
   input wire logic clock_i, // Clock
   output logic valid_o, // Token pulse
   output logic [3:0] pid_o, // Token PID
   output logic hs_o, // High-speed token
   output logic ok_o // CRC and address good
);
   initial
   begin
      valid_o = 1'b0;
      pid_o = 4'h0;
      hs_o = 1'b0;
      ok_o = 1'b0;
   end
   // One-cycle token, then scrambled idle fields
   task send_token(input logic [3:0] p, input logic h, input logic k);
      @(posedge clock_i);
      valid_o <= 1'b1;
      pid_o <= p;
      hs_o <= h;
      ok_o <= k;
      @(posedge clock_i);
      valid_o <= 1'b0;
      pid_o <= ~p;
      hs_o <= ~h;
      ok_o <= ~k;
   endtask : send_token
endmodule : utmc_host_model

// ==== tb.sv ====
// Purpose: Bench for the test-mode control block.
// Assumes: Avalon master waits for waitrequest low.
// Notes: Output vector is speed, chirp, drive, dp, dm, hs, ignore.
`timescale 1ns/1ps
module tb
   import utmc_pkg::*;
;
   logic clock_i = 1'b0, reset_i = 1'b1, bus_reset_i = 1'b0;
   logic [7:0] avs_address_i = 8'h00;
   logic avs_read_i = 1'b0, avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0000_0000, avs_readdata_o, q;
   logic [3:0] avs_byteenable_i = 4'hf, token_pid_i, handshake_pid_o;
   logic avs_waitrequest_o, token_valid_i, token_hs_i, token_crc_ok_i, handshake_send_o;
   logic rx_ignore_o, chirp_enable_o, line_drive_o, dp_o, dm_o, hs_mode_o;
   logic [1:0] speed_sel_o;
   logic [15:0] s1, s2;
   int n_errors = 0, check_count = 0;
   wire [7:0] outs = {speed_sel_o, chirp_enable_o, line_drive_o, dp_o, dm_o, hs_mode_o, rx_ignore_o};
   utmc_ctrl i_dut
   (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .bus_reset_i(bus_reset_i),
      .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i),
      .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i),
      .avs_byteenable_i(avs_byteenable_i),
      .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o),
      .token_valid_i(token_valid_i),
      .token_pid_i(token_pid_i),
      .token_hs_i(token_hs_i),
      .token_crc_ok_i(token_crc_ok_i),
      .handshake_send_o(handshake_send_o),
      .handshake_pid_o(handshake_pid_o),
      .rx_ignore_o(rx_ignore_o),
      .speed_sel_o(speed_sel_o),
      .chirp_enable_o(chirp_enable_o),
      .line_drive_o(line_drive_o),
      .dp_o(dp_o),
      .dm_o(dm_o),
      .hs_mode_o(hs_mode_o)
   );
   utmc_host_model i_host (.clock_i(clock_i), .valid_o(token_valid_i), .pid_o(token_pid_i),
      .hs_o(token_hs_i), .ok_o(token_crc_ok_i));
   always #5 clock_i = ~clock_i;
   // Verdict and end of run
   task complete_run;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : complete_run
   // Compare and count
   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // One Avalon access, held until waitrequest is sampled low
   task access(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clock_i);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= w;
      avs_read_i <= ~w;
      for (i = 0; i < 20; i++)
      begin
         @(posedge clock_i);
         if (avs_waitrequest_o === 1'b0)
            break;
      end
      q = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
      if (i == 20)
      begin
         n_errors++;
         complete_run();
      end
   endtask : access
   // Write a mode, read it back, compare the masked output vector
   task mode(input logic [7:0] v, input logic [7:0] e, input logic [7:0] m);
      access(1'b1, UTMC_TEST_CTRL_ADDR, {24'h00_0000, v});
      access(1'b0, UTMC_TEST_CTRL_ADDR, 32'h0000_0000);
      chk(q, {24'h00_0000, v & UTMC_WRITE_MASK});
      chk({24'h00_0000, outs & m}, {24'h00_0000, e});
   endtask : mode
   // Send a token and look for the handshake one cycle later
   task tok(input logic [3:0] p, input logic h, input logic k, input logic e);
      i_host.send_token(p, h, k);
      @(posedge clock_i);
      chk({31'h0, handshake_send_o}, {31'h0, e});
      if (e)
         chk({28'h0, handshake_pid_o}, {28'h0, UTMC_PID_NAK});
   endtask : tok
   // Record sixteen cycles of DP
   task grab(output logic [15:0] s);
      for (int k = 0; k < 16; k++)
      begin
         @(posedge clock_i);
         s[k] = dp_o;
      end
   endtask : grab
   // Main sequence
   initial
   begin
      repeat (16) @(posedge clock_i);
      reset_i <= 1'b0;
      access(1'b0, UTMC_TEST_CTRL_ADDR, 32'h0000_0000);
      chk(q, 32'h0000_0000);
      chk({24'h00_0000, outs}, 32'h0000_0020);
      access(1'b1, 8'h40, 32'h0000_00ff);
      access(1'b0, 8'h40, 32'h0000_0000);
      chk(q, 32'h0000_0000);
      avs_byteenable_i <= 4'he;
      access(1'b1, UTMC_TEST_CTRL_ADDR, 32'h0000_0004);
      avs_byteenable_i <= 4'hf;
      access(1'b0, UTMC_TEST_CTRL_ADDR, 32'h0000_0000);
      chk(q, 32'h0000_0000);
      mode(8'he0, 8'h42, 8'hff);
      mode(8'h10, 8'h80, 8'hff);
      mode(8'h04, 8'h34, 8'hff);
      tok(UTMC_PID_IN, 1'b1, 1'b1, 1'b0);
      mode(8'h02, 8'h38, 8'hff);
      mode(8'h01, 8'h33, 8'hff);
      tok(UTMC_PID_IN, 1'b1, 1'b1, 1'b1);
      tok(4'h1, 1'b1, 1'b1, 1'b0);
      tok(UTMC_PID_IN, 1'b0, 1'b1, 1'b0);
      tok(UTMC_PID_IN, 1'b1, 1'b0, 1'b0);
      mode(8'h08, 8'h32, 8'hf3);
      grab(s1);
      chk({31'h0, dp_o ^ dm_o}, 32'h0000_0001);
      chk({31'h0, s1 != 16'h0000 && s1 != 16'hffff}, 32'h0000_0001);
      mode(8'h00, 8'h20, 8'hff);
      mode(8'h08, 8'h32, 8'hf3);
      grab(s2);
      chk({16'h0000, s2}, {16'h0000, s1});
      mode(8'h00, 8'h20, 8'hff);
      access(1'b0, UTMC_STATUS_ADDR, 32'h0000_0000);
      chk(q & 32'h0000_0100, 32'h0000_0100);
      mode(8'h84, 8'h56, 8'hff);
      bus_reset_i <= 1'b1;
      @(posedge clock_i);
      bus_reset_i <= 1'b0;
      access(1'b0, UTMC_TEST_CTRL_ADDR, 32'h0000_0000);
      chk(q, 32'h0000_0080);
      chk({24'h00_0000, outs}, 32'h0000_0042);
      // Hardware reset in mid-run clears every bit and the entry flag
      reset_i <= 1'b1;
      repeat (16) @(posedge clock_i);
      reset_i <= 1'b0;
      access(1'b0, UTMC_TEST_CTRL_ADDR, 32'h0000_0000);
      chk(q, 32'h0000_0000);
      chk({24'h00_0000, outs}, 32'h0000_0020);
      access(1'b0, UTMC_STATUS_ADDR, 32'h0000_0000);
      chk(q, 32'h0000_0000);
      complete_run();
   end
endmodule : tb
